// ---- msh_regs.vh ----
// Notes on behaviour
// - Diagnostic query 08 with subfunction 0000 is echoed byte for byte, check included.
// - Address 0 is invalid for diagnostic and access-log queries; such frames are ignored.
// - No response frame is ever sent for a broadcast query.
// - Multiple write 10 accepts address 0 as broadcast, writes, and stays silent.
// - Write query: address, function, start hi/lo, count hi/lo, byte count, data, check lo/hi.
// - Data words arrive high byte first and go to consecutive ascending registers.
// - Starting address field is register number minus 40001.
// - A multiple write carries at most 125 registers.
// - Byte count equals twice the register count, range 02 to fa.
// - Good non-broadcast write answers address, function, start, count, fresh check.
// - Access-log query 46 returns first register and count of registers that took data last time.
// - Log records only 10 accesses; any other function, 03 included, leaves zero and zero.
// - Logged start uses the query encoding, register number minus 40001.
// - Log answer: address, 46, start hi/lo, count hi/lo, check lo/hi.
// - Illegal function, address or data answers function plus 80 and code 01/02/03.
// - Parity, check, overrun, framing or busy errors get no response.
// - Frame under 4 bytes is a frame error; counter increments, alarm asserts.
// - Write with some missing registers succeeds if one register took the data.
`ifndef MSH_REGS_VH
`define MSH_REGS_VH
`define MSH_FC_READ 8'h03
`define MSH_FC_DIAG 8'h08
`define MSH_FC_WRMULT 8'h10
`define MSH_FC_LOG 8'h46
`define MSH_DIAG_SUB 16'h0000
`define MSH_EXC_FLAG 8'h80
`define MSH_EXC_NONE 8'h00
`define MSH_EXC_FUNC 8'h01
`define MSH_EXC_ADDR 8'h02
`define MSH_EXC_DATA 8'h03
`define MSH_BCAST 8'h00
`define MSH_MAX_REGS 16'h007d
`define MSH_BC_MIN 8'h02
`define MSH_BC_MAX 8'hfa
`define MSH_MIN_FRAME 9'h004
`define MSH_DIAG_LEN 9'h008
`define MSH_LOG_QLEN 9'h004
`define MSH_WR_HDR 9'h009
`define MSH_WR_DATA 9'h007
`define MSH_RSP_EXC 9'h003
`define MSH_RSP_FULL 9'h006
`define MSH_CRC_INIT 16'hffff
`define MSH_CRC_POLY 16'ha001
`define MSH_BUF_DEPTH 259
`endif

// ---- msh_crc16.v ----
`timescale 1ns/1ps
`default_nettype none
`include "msh_regs.vh"
// One byte step of the reflected CRC-16
module msh_crc16 (
	input wire [15:0] crc_i,
	input wire [7:0] data_i,
	output reg [15:0] crc_o
);
	integer i;
	always @* begin
		crc_o = crc_i ^ {8'h00, data_i};
		for (i = 0; i < 8; i = i + 1) begin
			if (crc_o[0]) begin
				crc_o = (crc_o >> 1) ^ `MSH_CRC_POLY;
			end else begin
				crc_o = crc_o >> 1;
			end
		end
	end
endmodule // msh_crc16
`default_nettype wire

// ---- msh_func_handler.v ----
`timescale 1ns/1ps
`default_nettype none
`include "msh_regs.vh"
module msh_func_handler #(
	parameter DEPTH = `MSH_BUF_DEPTH,
	parameter LW = 9
) (
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire rx_valid_i,
	input wire [7:0] rx_data_i,
	input wire rx_end_i,
	input wire rx_err_i,
	input wire [7:0] own_addr_i,
	output wire hr_wr_o,
	output wire [15:0] hr_addr_o,
	output wire [15:0] hr_wdata_o,
	input wire hr_ok_i,
	output wire tx_valid_o,
	output wire [7:0] tx_data_o,
	output wire tx_last_o,
	input wire tx_ready_i,
	output wire alarm_o,
	input wire alarm_clr_i,
	output wire [15:0] err_cnt_o
);
	localparam [4:0] S_RX = 5'h01;
	localparam [4:0] S_CHK = 5'h02;
	localparam [4:0] S_WR = 5'h04;
	localparam [4:0] S_WEND = 5'h08;
	localparam [4:0] S_TX = 5'h10;

	reg [7:0] buf_q [0:DEPTH-1];
	reg [4:0] state_q;
	reg [LW-1:0] len_q, tx_len_q, tx_idx_q;
	reg [15:0] rx_crc_q, log_addr_q, log_cnt_q, wr_first_q, hr_addr_q, hr_wdata_q, tx_crc_q, err_cnt_q;
	reg [7:0] wr_idx_q, wr_cnt_q, wr_ok_q, tx_data_q;
	reg bad_q, hr_wr_q, tx_raw_q, tx_valid_q, alarm_q;

	wire [15:0] rx_crc_nx;
	wire [15:0] tx_crc_nx;
	msh_crc16 u_rx_crc (
		.crc_i(rx_crc_q),
		.data_i(rx_data_i),
		.crc_o(rx_crc_nx)
	);
	msh_crc16 u_tx_crc (
		.crc_i(tx_crc_q),
		.data_i(tx_data_q),
		.crc_o(tx_crc_nx)
	);

	wire [7:0] f_addr = buf_q[0];
	wire [7:0] f_fc = buf_q[1];
	wire [15:0] f_start = {buf_q[2], buf_q[3]};
	wire [15:0] f_cnt = {buf_q[4], buf_q[5]};
	wire [7:0] f_bc = buf_q[6];
	wire is_bc = (f_addr == `MSH_BCAST);
	wire for_me = (f_addr == own_addr_i) || is_bc;
	wire chk_err = bad_q || (len_q < `MSH_MIN_FRAME) || (rx_crc_q != 16'h0000);
	wire busy = (state_q != S_RX) && (state_q != S_CHK);
	wire err_evt = ((state_q == S_CHK) && chk_err) || (busy && rx_end_i);
	wire [LW-1:0] wr_pos = `MSH_WR_DATA + {wr_idx_q, 1'b0};
	wire [LW-1:0] tx_nidx = tx_idx_q + 1'b1;
	wire [LW-1:0] tx_end = tx_raw_q ? (tx_len_q - 1'b1) : (tx_len_q + 1'b1);
	wire tx_fire = tx_valid_q && tx_ready_i;

	reg chk_drop, chk_echo, chk_log, chk_wr;
	reg [7:0] chk_exc;
	always @* begin
		chk_drop = 1'b0;
		chk_echo = 1'b0;
		chk_log = 1'b0;
		chk_wr = 1'b0;
		chk_exc = `MSH_EXC_NONE;
		if (chk_err || !for_me) begin
			chk_drop = 1'b1;
		end else begin
			case (f_fc)
				`MSH_FC_DIAG: begin
					if (is_bc) begin
						chk_drop = 1'b1;
					end else if (len_q != `MSH_DIAG_LEN) begin
						chk_exc = `MSH_EXC_DATA;
					end else if (f_start != `MSH_DIAG_SUB) begin
						chk_exc = `MSH_EXC_FUNC;
					end else begin
						chk_echo = 1'b1;
					end
				end
				`MSH_FC_WRMULT: begin
					if (f_cnt == 16'h0000 || f_cnt > `MSH_MAX_REGS || f_bc < `MSH_BC_MIN ||
							f_bc > `MSH_BC_MAX || {1'b0, f_bc} != {f_cnt[7:0], 1'b0} ||
							len_q != `MSH_WR_HDR + {1'b0, f_bc}) begin
						chk_exc = `MSH_EXC_DATA;
					end else begin
						chk_wr = 1'b1;
					end
				end
				`MSH_FC_LOG: begin
					if (is_bc) begin
						chk_drop = 1'b1;
					end else if (len_q != `MSH_LOG_QLEN) begin
						chk_exc = `MSH_EXC_DATA;
					end else begin
						chk_log = 1'b1;
					end
				end
				default: begin
					chk_exc = `MSH_EXC_FUNC;
				end
			endcase
		end
	end

	// Frame buffer, reused in place for the answer
	always @(posedge sys_clk_i) begin
		if (state_q == S_RX && rx_valid_i && len_q < DEPTH) begin
			buf_q[len_q] <= rx_data_i;
		end
		if (state_q == S_CHK && !chk_drop && chk_exc != `MSH_EXC_NONE) begin
			buf_q[1] <= f_fc | `MSH_EXC_FLAG;
			buf_q[2] <= chk_exc;
		end
		if (state_q == S_CHK && chk_log) begin
			buf_q[2] <= log_addr_q[15:8];
			buf_q[3] <= log_addr_q[7:0];
			buf_q[4] <= log_cnt_q[15:8];
			buf_q[5] <= log_cnt_q[7:0];
		end
		if (state_q == S_WEND && wr_ok_q == 8'h00) begin
			buf_q[1] <= f_fc | `MSH_EXC_FLAG;
			buf_q[2] <= `MSH_EXC_ADDR;
		end
	end

	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= S_RX;
			len_q <= {LW{1'b0}};
			rx_crc_q <= `MSH_CRC_INIT;
			bad_q <= 1'b0;
			log_addr_q <= 16'h0000;
			log_cnt_q <= 16'h0000;
			wr_idx_q <= 8'h00;
			wr_cnt_q <= 8'h00;
			wr_ok_q <= 8'h00;
			wr_first_q <= 16'h0000;
			hr_wr_q <= 1'b0;
			hr_addr_q <= 16'h0000;
			hr_wdata_q <= 16'h0000;
			tx_raw_q <= 1'b0;
			tx_len_q <= {LW{1'b0}};
			tx_idx_q <= {LW{1'b0}};
			tx_crc_q <= `MSH_CRC_INIT;
			tx_valid_q <= 1'b0;
			tx_data_q <= 8'h00;
			err_cnt_q <= 16'h0000;
			alarm_q <= 1'b0;
		end else begin
			if (err_evt) begin
				err_cnt_q <= err_cnt_q + 16'h0001;
			end
			alarm_q <= err_evt | (alarm_q & ~alarm_clr_i);
			if ((busy && rx_valid_i) || (state_q == S_RX && rx_err_i)) begin
				bad_q <= 1'b1;
			end else if (busy && rx_end_i) begin
				bad_q <= 1'b0;
			end
			case (state_q)
				S_RX: begin
					if (rx_valid_i) begin
						if (len_q < DEPTH) begin
							len_q <= len_q + 1'b1;
							rx_crc_q <= rx_crc_nx;
						end else begin
							bad_q <= 1'b1;
						end
					end
					if (rx_end_i) begin
						state_q <= S_CHK;
					end
				end
				S_CHK: begin
					len_q <= {LW{1'b0}};
					rx_crc_q <= `MSH_CRC_INIT;
					if (!busy && !rx_valid_i) begin
						bad_q <= 1'b0;
					end
					tx_data_q <= f_addr;
					tx_idx_q <= {LW{1'b0}};
					tx_crc_q <= `MSH_CRC_INIT;
					tx_raw_q <= chk_echo;
					tx_len_q <= chk_echo ? len_q : (chk_log ? `MSH_RSP_FULL : `MSH_RSP_EXC);
					if (!chk_drop && !chk_wr) begin
						log_addr_q <= 16'h0000;
						log_cnt_q <= 16'h0000;
					end
					if (chk_drop) begin
						state_q <= S_RX;
					end else if (chk_wr) begin
						wr_idx_q <= 8'h00;
						wr_cnt_q <= f_cnt[7:0];
						wr_ok_q <= 8'h00;
						state_q <= S_WR;
					end else if (is_bc) begin
						state_q <= S_RX;
					end else begin
						tx_valid_q <= 1'b1;
						state_q <= S_TX;
					end
				end
				S_WR: begin
					hr_wr_q <= (wr_idx_q < wr_cnt_q);
					if (wr_idx_q < wr_cnt_q) begin
						hr_addr_q <= f_start + {8'h00, wr_idx_q};
						hr_wdata_q <= {buf_q[wr_pos], buf_q[wr_pos + 1'b1]};
						wr_idx_q <= wr_idx_q + 8'h01;
					end
					if (hr_wr_q && hr_ok_i) begin
						wr_ok_q <= wr_ok_q + 8'h01;
						if (wr_ok_q == 8'h00) begin
							wr_first_q <= hr_addr_q;
						end
					end
					if (!hr_wr_q && wr_idx_q == wr_cnt_q) begin
						state_q <= S_WEND;
					end
				end
				S_WEND: begin
					log_addr_q <= (wr_ok_q == 8'h00) ? 16'h0000 : wr_first_q;
					log_cnt_q <= {8'h00, wr_ok_q};
					tx_len_q <= (wr_ok_q == 8'h00) ? `MSH_RSP_EXC : `MSH_RSP_FULL;
					if (is_bc) begin
						state_q <= S_RX;
					end else begin
						tx_valid_q <= 1'b1;
						state_q <= S_TX;
					end
				end
				S_TX: begin
					if (tx_fire) begin
						if (tx_idx_q == tx_end) begin
							tx_valid_q <= 1'b0;
							state_q <= S_RX;
						end else begin
							tx_idx_q <= tx_nidx;
							if (!tx_raw_q && tx_idx_q < tx_len_q) begin
								tx_crc_q <= tx_crc_nx;
							end
							if (tx_raw_q || tx_nidx < tx_len_q) begin
								tx_data_q <= buf_q[tx_nidx];
							end else if (tx_nidx == tx_len_q) begin
								tx_data_q <= tx_crc_nx[7:0];
							end else begin
								tx_data_q <= tx_crc_q[15:8];
							end
						end
					end
				end
				default: begin
					state_q <= S_RX;
				end
			endcase
		end
	end

	assign hr_wr_o = hr_wr_q;
	assign hr_addr_o = hr_addr_q;
	assign hr_wdata_o = hr_wdata_q;
	assign tx_valid_o = tx_valid_q;
	assign tx_data_o = tx_data_q;
	assign tx_last_o = tx_valid_q && (tx_idx_q == tx_end);
	assign alarm_o = alarm_q;
	assign err_cnt_o = err_cnt_q;
endmodule // msh_func_handler
`default_nettype wire

// ---- msh_func_handler_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module msh_func_handler_monitor (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic rx_end_i,
	input wire logic [7:0] own_addr_i,
	input wire logic alarm_clr_i,
	input wire logic hr_wr_o,
	input wire logic [15:0] hr_addr_o,
	input wire logic tx_valid_o,
	input wire logic [7:0] tx_data_o,
	input wire logic tx_last_o,
	input wire logic tx_ready_i,
	input wire logic alarm_o,
	input wire logic [15:0] err_cnt_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_last_in_byte: assert property (tx_last_o |-> tx_valid_o)
		else $error("last flag alone");
	a_stall_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o))
		else $error("byte lost in stall");
	a_reply_own_addr: assert property (tx_valid_o && !$past(tx_valid_o) |-> tx_data_o == own_addr_i)
		else $error("reply not own address");
	a_wr_ascend: assert property (hr_wr_o && $past(hr_wr_o) |-> hr_addr_o == $past(hr_addr_o) + 16'h0001)
		else $error("write address step");
	a_wr_no_tx: assert property (hr_wr_o |-> !tx_valid_o)
		else $error("reply during writes");
	a_wr_start: assert property ($rose(hr_wr_o) |-> $past(rx_end_i, 2) || $past(rx_end_i, 3))
		else $error("write start late");
	a_err_step: assert property (err_cnt_o != $past(err_cnt_o) |-> err_cnt_o == $past(err_cnt_o) + 16'h0001 && alarm_o)
		else $error("error count step");
	a_alarm_sticky: assert property (alarm_o && !alarm_clr_i |=> alarm_o)
		else $error("alarm dropped");
	c_two_writes: cover property (hr_wr_o ##1 hr_wr_o);
	c_reply_end: cover property (tx_last_o && tx_ready_i);
	c_alarm: cover property ($rose(alarm_o));
endmodule // msh_func_handler_monitor
bind msh_func_handler msh_func_handler_monitor u_mon (.sys_clk_i, .rst_n_i, .rx_end_i, .own_addr_i, .alarm_clr_i,
	.hr_wr_o, .hr_addr_o, .tx_valid_o, .tx_data_o, .tx_last_o, .tx_ready_i, .alarm_o, .err_cnt_o);
`default_nettype wire

// ---- msh_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module msh_master_model (
	input wire logic clk_i,
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	output logic rx_end_o,
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	input wire logic tx_last_i,
	output logic tx_ready_o
);
	logic [7:0] rsp[$];
	logic done = 1'b0;
	logic slow = 1'b0;
	initial begin
		rx_valid_o = 1'b0;
		rx_data_o = 8'h00;
		rx_end_o = 1'b0;
		tx_ready_o = 1'b0;
	end
	function automatic logic [15:0] crc(input byte unsigned f[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (f[i]) begin
			c = c ^ {8'h00, f[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		return c;
	endfunction
	always @(posedge clk_i) begin
		if (tx_valid_i && tx_ready_o) begin
			rsp.push_back(tx_data_i);
			done <= tx_last_i;
		end
		tx_ready_o <= #1 slow ? ~tx_ready_o : 1'b1;
	end
	// line order, check low then high
	task automatic send(input byte unsigned f[$], input logic bad, input logic slw);
		logic [15:0] c;
		c = crc(f) ^ {16{bad}};
		f.push_back(c[7:0]);
		f.push_back(c[15:8]);
		rsp.delete();
		done = 1'b0;
		slow = slw;
		foreach (f[i]) begin
			@(posedge clk_i);
			#1 rx_valid_o = 1'b1;
			rx_data_o = f[i];
			rx_end_o = (i == f.size() - 1);
		end
		@(posedge clk_i);
		#1 rx_valid_o = 1'b0;
		rx_end_o = 1'b0;
		rx_data_o = ~rx_data_o;
		repeat (300) if (!done) @(posedge clk_i);
	endtask
endmodule // msh_master_model
`default_nettype wire

// ---- msh_func_handler_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module msh_func_handler_tb_top;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic alarm_clr_i = 1'b0;
	logic rx_err_i = 1'b0;
	logic [15:0] hr_bad_addr = 16'hffff;
	wire hr_ok_i;
	logic rx_valid_i, rx_end_i, tx_ready_i, hr_wr_o, tx_valid_o, tx_last_o, alarm_o;
	logic [7:0] rx_data_i, tx_data_o;
	logic [15:0] hr_addr_o, hr_wdata_o, err_cnt_o;
	logic [15:0] wa[$];
	logic [15:0] wd[$];
	int err_count = 0;
	int compares = 0;
	always #2 sys_clk_i = ~sys_clk_i;
	msh_func_handler dut (.sys_clk_i, .rst_n_i, .rx_valid_i, .rx_data_i, .rx_end_i, .rx_err_i,
		.own_addr_i(8'h19), .hr_wr_o, .hr_addr_o, .hr_wdata_o, .hr_ok_i, .tx_valid_o, .tx_data_o,
		.tx_last_o, .tx_ready_i, .alarm_o, .alarm_clr_i, .err_cnt_o);
	msh_master_model mm (.clk_i(sys_clk_i), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .rx_end_o(rx_end_i),
		.tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_last_i(tx_last_o), .tx_ready_o(tx_ready_i));
	// Store refuses one chosen register
	assign #1 hr_ok_i = (hr_addr_o != hr_bad_addr);
	always @(posedge sys_clk_i) if (hr_wr_o === 1'b1) begin
		wa.push_back(hr_addr_o);
		wd.push_back(hr_wdata_o);
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s %h/%h", $time, m, got, exp);
		end
	endtask
	task automatic chk_rsp(input byte unsigned e[$]);
		logic [15:0] c;
		c = mm.crc(e);
		e.push_back(c[7:0]);
		e.push_back(c[15:8]);
		chk(16'(mm.rsp.size()), 16'(e.size()), "length");
		foreach (e[i]) chk({8'h00, mm.rsp[i]}, {8'h00, e[i]}, "byte");
		chk({15'h0000, mm.done}, 16'h0001, "last flag");
	endtask
	task automatic t_echo();
		mm.send({8'h19, 8'h08, 8'h00, 8'h00, 8'hab, 8'hcd}, 1'b0, 1'b1);
		chk_rsp({8'h19, 8'h08, 8'h00, 8'h00, 8'hab, 8'hcd});
		mm.send({8'h19, 8'h08, 8'h00, 8'h00, 8'hff, 8'hff}, 1'b0, 1'b0);
		chk_rsp({8'h19, 8'h08, 8'h00, 8'h00, 8'hff, 8'hff});
	endtask
	task automatic t_write_log();
		mm.send({8'h19, 8'h10, 8'h03, 8'hee, 8'h00, 8'h02, 8'h04, 8'h00, 8'h05, 8'h00, 8'h0a}, 1'b0, 1'b1);
		chk_rsp({8'h19, 8'h10, 8'h03, 8'hee, 8'h00, 8'h02});
		chk(wa[0], 16'h03ee, "addr");
		chk(wd[0], 16'h0005, "word");
		chk(wa[1], 16'h03ef, "addr");
		chk(wd[1], 16'h000a, "word");
		mm.send({8'h19, 8'h46}, 1'b0, 1'b0);
		chk_rsp({8'h19, 8'h46, 8'h03, 8'hee, 8'h00, 8'h02});
		mm.send({8'h19, 8'h46}, 1'b0, 1'b1);
		chk_rsp({8'h19, 8'h46, 8'h00, 8'h00, 8'h00, 8'h00});
	endtask
	task automatic t_silent();
		wa.delete();
		wd.delete();
		mm.send({8'h00, 8'h10, 8'h00, 8'h01, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34}, 1'b0, 1'b0);
		chk(16'(mm.rsp.size()), 16'h0000, "broadcast");
		chk(wd[0], 16'h1234, "broadcast word");
		mm.send({8'h00, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34}, 1'b0, 1'b0);
		chk(16'(mm.rsp.size()), 16'h0000, "zero addr");
		mm.send({8'h22, 8'h46}, 1'b0, 1'b0);
		chk(16'(mm.rsp.size()), 16'h0000, "other addr");
	endtask
	task automatic t_store();
		wa.delete();
		hr_bad_addr = 16'h0010;
		mm.send({8'h19, 8'h10, 8'h00, 8'h10, 8'h00, 8'h02, 8'h04, 8'haa, 8'hbb, 8'hcc, 8'hdd}, 1'b0, 1'b0);
		chk_rsp({8'h19, 8'h10, 8'h00, 8'h10, 8'h00, 8'h02});
		chk(wa[1], 16'h0011, "second addr");
		mm.send({8'h19, 8'h46}, 1'b0, 1'b0);
		chk_rsp({8'h19, 8'h46, 8'h00, 8'h11, 8'h00, 8'h01});
		mm.send({8'h19, 8'h10, 8'h00, 8'h10, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34}, 1'b0, 1'b0);
		chk_rsp({8'h19, 8'h90, 8'h02});
		hr_bad_addr = 16'hffff;
	endtask
	task automatic t_errors();
		logic [15:0] n;
		n = err_cnt_o;
		mm.send({8'h19, 8'h10, 8'h00, 8'h00, 8'h00, 8'h02, 8'h03, 8'h00, 8'h01, 8'h00}, 1'b0, 1'b0);
		chk_rsp({8'h19, 8'h90, 8'h03});
		mm.send({8'h19, 8'h06, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0, 1'b0);
		chk_rsp({8'h19, 8'h86, 8'h01});
		mm.send({8'h19, 8'h08, 8'h00, 8'h01, 8'h00, 8'h00}, 1'b0, 1'b0);
		chk_rsp({8'h19, 8'h88, 8'h01});
		mm.send({8'h19, 8'h10, 8'h00, 8'h00, 8'h00, 8'h7e, 8'hfc}, 1'b0, 1'b0);
		chk_rsp({8'h19, 8'h90, 8'h03});
		mm.send({8'h19, 8'h46, 8'h00}, 1'b0, 1'b0);
		chk_rsp({8'h19, 8'hc6, 8'h03});
		mm.send({8'h19}, 1'b0, 1'b0);
		chk(err_cnt_o, n + 16'h0001, "short");
		mm.send({8'h19, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00}, 1'b1, 1'b0);
		chk(16'(mm.rsp.size()), 16'h0000, "bad check");
		chk(err_cnt_o, n + 16'h0002, "bad check");
		fork
			mm.send({8'h19, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00}, 1'b0, 1'b0);
			begin
				@(posedge sys_clk_i);
				#1 rx_err_i = 1'b1;
				@(posedge sys_clk_i);
				#1 rx_err_i = 1'b0;
			end
		join
		chk(16'(mm.rsp.size()), 16'h0000, "line error");
		chk(err_cnt_o, n + 16'h0003, "line error");
		chk({15'h0000, alarm_o}, 16'h0001, "alarm set");
		@(posedge sys_clk_i);
		#1 alarm_clr_i = 1'b1;
		@(posedge sys_clk_i);
		#1 alarm_clr_i = 1'b0;
		chk({15'h0000, alarm_o}, 16'h0000, "alarm clear");
	endtask
	task automatic tally_and_finish();
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge sys_clk_i);
		#1 rst_n_i = 1'b1;
		t_echo();
		t_write_log();
		t_silent();
		t_store();
		t_errors();
		tally_and_finish();
	end
	initial begin
		#100000;
		err_count++;
		tally_and_finish();
	end
endmodule // msh_func_handler_tb_top
`default_nettype wire
